// *** rtl/llu_pkg.sv ***
// Shared constants and types of the load-linked unit.
// Assumes a 32-bit core clocked at 10 MHz with one synchronous reset.
package llu_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Instruction encoding fields
	localparam logic [5:0] LLU_MAJOR_GROUP_C = 6'h18;
	localparam logic [3:0] LLU_SUB_SINGLE    = 4'h3;
	localparam logic [3:0] LLU_SUB_USER_MAP  = 4'h6;
	localparam logic [3:0] LLU_SUB_PAIRED    = 4'h1;
	localparam logic [2:0] LLU_CODE_ZERO     = 3'h0;
	localparam logic [2:0] LLU_CODE_USER_LL  = 3'h6;
	localparam logic [3:0] LLU_PAIR_TAIL     = 4'h0;
	localparam int         LLU_OFFSET_W      = 9;

	////////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses on the Wishbone bus)
	localparam logic [3:0]  LLU_ADDR_CTRL     = 4'h0;
	localparam logic [3:0]  LLU_ADDR_STATUS   = 4'h4;
	localparam logic [3:0]  LLU_ADDR_LINK     = 4'h8;
	localparam int          LLU_CTRL_EVA_BIT  = 0;
	localparam int          LLU_CTRL_XNP_BIT  = 1;
	localparam int          LLU_CTRL_CU0_BIT  = 2;
	localparam logic [2:0]  LLU_CTRL_RESET    = 3'h0;
	localparam int          LLU_STAT_LINK_BIT = 0;
	localparam int          LLU_STAT_BUSY_BIT = 1;

	////////////////////////////////////////////////////////////////////////////
	// Translation fault codes from the memory path
	localparam logic [1:0] LLU_MEM_OK      = 2'h0;
	localparam logic [1:0] LLU_MEM_REFILL  = 2'h1;
	localparam logic [1:0] LLU_MEM_INVALID = 2'h2;
	localparam logic [1:0] LLU_MEM_WATCH   = 2'h3;

	// Segment access modes reported by translation
	localparam logic [1:0] LLU_SEG_MAPPED_USER_SUPER_UNMAPPED_KERNEL_MODE = 2'h0;
	localparam logic [1:0] LLU_SEG_UNMAPPED_USER_SUPER_KERNEL_MODE  = 2'h1;
	localparam logic [1:0] LLU_SEG_MAPPED_USER_SUPER_KERNEL_MODE  = 2'h2;

	// Word step between the two halves of a paired read
	localparam logic [31:0] LLU_WORD_STEP = 32'h0000_0004;

	typedef enum logic [1:0] {
		LLU_KIND_NONE,
		LLU_KIND_SINGLE,
		LLU_KIND_USER,
		LLU_KIND_PAIRED
	} llu_kind_t;

	typedef enum logic [2:0] {
		LLU_EXC_NONE,
		LLU_EXC_ADDR_ERR,
		LLU_EXC_TLB_REFILL,
		LLU_EXC_TLB_INVALID,
		LLU_EXC_WATCH,
		LLU_EXC_RESERVED,
		LLU_EXC_CP_UNUSABLE
	} llu_exc_t;

endpackage : llu_pkg

// *** rtl/llu_decode.sv ***
// Combinational decoder for the load-linked encodings.
// Assumes the instruction word is stable while instr_valid_i is high.
module llu_decode
	import llu_pkg::*;
(
	input  wire logic [31:0] instr_i,
	output llu_kind_t        kind_o,
	output logic      [4:0]  rt_o,
	output logic      [4:0]  rd_o,
	output logic      [31:0] offset_o
);

	////////////////////////////////////////////////////////////////////////////
	// Field recognition
	logic group_c;
	logic is_single;
	logic is_user;
	logic is_paired;

	assign group_c   = (instr_i[31:26] == LLU_MAJOR_GROUP_C);
	assign is_single = group_c && (instr_i[15:12] == LLU_SUB_SINGLE)
		&& (instr_i[11:9] == LLU_CODE_ZERO);
	assign is_user   = group_c && (instr_i[15:12] == LLU_SUB_USER_MAP)
		&& (instr_i[11:9] == LLU_CODE_USER_LL);
	assign is_paired = group_c && (instr_i[15:12] == LLU_SUB_PAIRED)
		&& (instr_i[11:9] == LLU_CODE_ZERO)
		&& (instr_i[3:0] == LLU_PAIR_TAIL);

	// Register fields and the offset
	always_comb begin
		kind_o   = LLU_KIND_NONE;
		rt_o     = instr_i[25:21];
		rd_o     = instr_i[8:4];
		offset_o = {{(32 - LLU_OFFSET_W){instr_i[8]}}, instr_i[8:0]};
		if (is_single) begin
			kind_o = LLU_KIND_SINGLE;
		end else if (is_user) begin
			kind_o = LLU_KIND_USER;
		end else if (is_paired) begin
			kind_o   = LLU_KIND_PAIRED;
			offset_o = 32'h0000_0000;
		end
	end

endmodule // llu_decode

// *** rtl/llu_unit.sv ***
// Load-linked execute unit: decode, address check, word or paired read,
// register writeback, link flag and link address, Wishbone control regs.
// Assumes the pipeline holds the base value with the instruction and that
// translation and memory answer on the same clock with a held request.
//
// Functional notes
// - Single-word form: group C, sub 0011, code 000, 9-bit offset.
// - Address is base plus sign-extended 9-bit offset.
// - Aligned word read goes into the target register.
// - Either low address bit set raises address error before translation.
// - Each execution starts a new sequence and sets the link flag.
// - A plain read only; nothing disturbs other processors' sequences.
// - An abandoned sequence needs no write; the flag simply stays.
// - Single form faults only: refill, invalid, address error, watch.
// - User-map form: group C, sub 0110, code 110, 9-bit offset.
// - User-map form uses user mapping; three user-reachable modes allowed.
// - User-map form exists only with the enhanced addressing bit set.
// - User-map form adds reserved and coprocessor-unusable faults.
// - Paired form: group C, sub 0001, code 000, rd, tail 0000.
// - Paired address is the base value unchanged.
// - Low word to target register, high word to upper destination.
// - Both word reads are locked together as one atomic pair.
// - Paired success writes aligned physical link address, flag in bit 0.
// - Paired form exists only when the no-pair bit is zero.
// - Without a cache the link address register may be left out.
// - Paired faults: refill, invalid, reserved, address error, watch.
module llu_unit
	import llu_pkg::*;
#(
	parameter bit HAS_LINK_ADDR = 1'b1
)(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Pipeline issue
	input  wire logic        instr_valid_i,
	input  wire logic [31:0] instr_i,
	input  wire logic [31:0] base_value_i,
	input  wire logic        link_clear_i,
	output logic             busy_o,
	// Translation and memory load path
	output logic             mem_req_o,
	output logic      [31:0] mem_vaddr_o,
	output logic             mem_user_map_o,
	output logic             mem_pair_lock_o,
	input  wire logic        mem_ack_i,
	input  wire logic [1:0]  mem_fault_i,
	input  wire logic [1:0]  mem_seg_mode_i,
	input  wire logic [31:0] mem_paddr_i,
	input  wire logic [31:0] mem_rdata_i,
	// Register file writeback and completion
	output logic             rf_we_o,
	output logic      [4:0]  rf_waddr_o,
	output logic      [31:0] rf_wdata_o,
	output logic             done_o,
	output logic             exc_valid_o,
	output llu_exc_t         exc_code_o,
	output logic             link_flag_o,
	output logic      [31:0] link_addr_o
);

	typedef enum logic [2:0] {
		LLU_S_IDLE,
		LLU_S_READ_LO,
		LLU_S_READ_HI,
		LLU_S_WB_HI
	} llu_state_t;

	llu_state_t state_q;
	llu_kind_t  kind;
	llu_kind_t  kind_q;
	logic [4:0]  rt;
	logic [4:0]  rd;
	logic [4:0]  rt_q;
	logic [4:0]  rd_q;
	logic [31:0] offset;
	logic [31:0] eff_addr;
	logic [31:0] lo_word_q;
	logic [31:0] hi_word_q;
	logic [31:0] paddr_q;
	logic [2:0]  ctrl_q;
	logic        accept;
	logic        misaligned;
	logic        seg_ok;
	logic        link_set;
	logic        link_clr;
	logic        wb_hit;
	llu_exc_t    fault_exc;

	////////////////////////////////////////////////////////////////////////////
	// Decode and address formation
	llu_decode u_decode (
		.instr_i  (instr_i),
		.kind_o   (kind),
		.rt_o     (rt),
		.rd_o     (rd),
		.offset_o (offset)
	);

	assign eff_addr = base_value_i + offset;
	assign accept   = instr_valid_i && !busy_o && (kind != LLU_KIND_NONE);
	// Misalignment is checked before any translation is asked for
	assign misaligned = (kind == LLU_KIND_PAIRED) ? (eff_addr[2:0] != 3'h0)
		: (eff_addr[1:0] != 2'h0);
	// User-map form may reach only the three user-accessible modes
	assign seg_ok = (mem_seg_mode_i == LLU_SEG_MAPPED_USER_SUPER_UNMAPPED_KERNEL_MODE) || (mem_seg_mode_i == LLU_SEG_UNMAPPED_USER_SUPER_KERNEL_MODE)
		|| (mem_seg_mode_i == LLU_SEG_MAPPED_USER_SUPER_KERNEL_MODE);

	// Translation faults map onto the short list every form allows
	always_comb begin
		case (mem_fault_i)
			LLU_MEM_REFILL:  fault_exc = LLU_EXC_TLB_REFILL;
			LLU_MEM_INVALID: fault_exc = LLU_EXC_TLB_INVALID;
			LLU_MEM_WATCH:   fault_exc = LLU_EXC_WATCH;
			default:         fault_exc = LLU_EXC_NONE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer: one instruction at a time, memory request held until ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q         <= LLU_S_IDLE;
			busy_o          <= 1'b0;
			mem_req_o       <= 1'b0;
			mem_vaddr_o     <= 32'h0000_0000;
			mem_user_map_o  <= 1'b0;
			mem_pair_lock_o <= 1'b0;
			rf_we_o         <= 1'b0;
			rf_waddr_o      <= 5'h00;
			rf_wdata_o      <= 32'h0000_0000;
			done_o          <= 1'b0;
			exc_valid_o     <= 1'b0;
			exc_code_o      <= LLU_EXC_NONE;
			kind_q          <= LLU_KIND_NONE;
			rt_q            <= 5'h00;
			rd_q            <= 5'h00;
			lo_word_q       <= 32'h0000_0000;
			hi_word_q       <= 32'h0000_0000;
			paddr_q         <= 32'h0000_0000;
		end else begin
			rf_we_o     <= 1'b0;
			done_o      <= 1'b0;
			exc_valid_o <= 1'b0;
			case (state_q)
				LLU_S_IDLE: begin
					if (accept) begin
						kind_q <= kind;
						rt_q   <= rt;
						rd_q   <= rd;
						if (kind == LLU_KIND_USER && !ctrl_q[LLU_CTRL_EVA_BIT]) begin
							exc_valid_o <= 1'b1;
							exc_code_o  <= LLU_EXC_RESERVED;
						end else if (kind == LLU_KIND_PAIRED && ctrl_q[LLU_CTRL_XNP_BIT]) begin
							exc_valid_o <= 1'b1;
							exc_code_o  <= LLU_EXC_RESERVED;
						end else if (kind == LLU_KIND_USER && !ctrl_q[LLU_CTRL_CU0_BIT]) begin
							exc_valid_o <= 1'b1;
							exc_code_o  <= LLU_EXC_CP_UNUSABLE;
						end else if (misaligned) begin
							exc_valid_o <= 1'b1;
							exc_code_o  <= LLU_EXC_ADDR_ERR;
						end else begin
							// A plain shared read; no ownership or invalidate is asked
							busy_o          <= 1'b1;
							state_q         <= LLU_S_READ_LO;
							mem_req_o       <= 1'b1;
							mem_vaddr_o     <= eff_addr;
							mem_user_map_o  <= (kind == LLU_KIND_USER);
							mem_pair_lock_o <= (kind == LLU_KIND_PAIRED);
						end
					end
				end
				LLU_S_READ_LO: begin
					if (mem_ack_i) begin
						mem_req_o <= 1'b0;
						if (fault_exc != LLU_EXC_NONE) begin
							mem_pair_lock_o <= 1'b0;
							busy_o          <= 1'b0;
							exc_valid_o     <= 1'b1;
							exc_code_o      <= fault_exc;
							state_q         <= LLU_S_IDLE;
						end else if (kind_q == LLU_KIND_USER && !seg_ok) begin
							busy_o      <= 1'b0;
							exc_valid_o <= 1'b1;
							exc_code_o  <= LLU_EXC_ADDR_ERR;
							state_q     <= LLU_S_IDLE;
						end else if (kind_q == LLU_KIND_PAIRED) begin
							// Lock stays up so no write lands between the halves
							lo_word_q   <= mem_rdata_i;
							paddr_q     <= {mem_paddr_i[31:3], 3'h0};
							mem_req_o   <= 1'b1;
							mem_vaddr_o <= mem_vaddr_o + LLU_WORD_STEP;
							state_q     <= LLU_S_READ_HI;
						end else begin
							rf_we_o    <= 1'b1;
							rf_waddr_o <= rt_q;
							rf_wdata_o <= mem_rdata_i;
							paddr_q    <= {mem_paddr_i[31:2], 2'h0};
							done_o     <= 1'b1;
							busy_o     <= 1'b0;
							state_q    <= LLU_S_IDLE;
						end
					end
				end
				LLU_S_READ_HI: begin
					if (mem_ack_i) begin
						mem_req_o       <= 1'b0;
						mem_pair_lock_o <= 1'b0;
						if (fault_exc != LLU_EXC_NONE) begin
							// Nothing of the pair is written on a fault
							busy_o      <= 1'b0;
							exc_valid_o <= 1'b1;
							exc_code_o  <= fault_exc;
							state_q     <= LLU_S_IDLE;
						end else begin
							hi_word_q  <= mem_rdata_i;
							rf_we_o    <= 1'b1;
							rf_waddr_o <= rt_q;
							rf_wdata_o <= lo_word_q;
							state_q    <= LLU_S_WB_HI;
						end
					end
				end
				LLU_S_WB_HI: begin
					rf_we_o    <= 1'b1;
					rf_waddr_o <= rd_q;
					rf_wdata_o <= hi_word_q;
					done_o     <= 1'b1;
					busy_o     <= 1'b0;
					state_q    <= LLU_S_IDLE;
				end
				default: begin
					state_q <= LLU_S_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link flag: set by every completion, a new one replaces the old sequence.
	// No timeout: an abandoned sequence just leaves the flag standing.
	assign link_set = ((state_q == LLU_S_READ_LO) && mem_ack_i && (fault_exc == LLU_EXC_NONE)
		&& (kind_q != LLU_KIND_PAIRED) && (kind_q != LLU_KIND_USER || seg_ok))
		|| (state_q == LLU_S_WB_HI);
	assign link_clr = link_clear_i || (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
		&& (wb_adr_i == LLU_ADDR_STATUS) && wb_sel_i[0] && !wb_dat_i[LLU_STAT_LINK_BIT]);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_flag_o <= 1'b0;
		end else if (link_set) begin
			link_flag_o <= 1'b1;
		end else if (link_clr) begin
			link_flag_o <= 1'b0;
		end
	end

	// Link address follows the aligned physical address, flag in bit 0
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_addr_o <= 32'h0000_0000;
		end else if (!HAS_LINK_ADDR) begin
			link_addr_o <= {31'h0000_0000, link_flag_o};
		end else if (state_q == LLU_S_WB_HI) begin
			link_addr_o <= {paddr_q[31:1], 1'b1};
		end else if (link_set) begin
			link_addr_o <= {mem_paddr_i[31:2], 2'h1};
		end else begin
			link_addr_o <= {link_addr_o[31:1], link_flag_o};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave: one wait state, unmapped reads return zero
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_hit;
			wb_dat_o <= 32'h0000_0000;
			if (wb_hit && !wb_we_i) begin
				case (wb_adr_i)
					LLU_ADDR_CTRL:   wb_dat_o <= {29'h0000_0000, ctrl_q};
					LLU_ADDR_STATUS: wb_dat_o <= {30'h0000_0000, busy_o, link_flag_o};
					LLU_ADDR_LINK:   wb_dat_o <= link_addr_o;
					default:         wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control bits steer decode legality; a write lands at the edge that sees ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= LLU_CTRL_RESET;
		end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
			&& (wb_adr_i == LLU_ADDR_CTRL) && wb_sel_i[0]) begin
			ctrl_q <= wb_dat_i[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking llu_cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_single_misalign: assert property (accept && kind == LLU_KIND_SINGLE
		&& eff_addr[1:0] != 2'h0 |=> exc_valid_o && exc_code_o == LLU_EXC_ADDR_ERR && !mem_req_o)
		else $error("misaligned single load did not fault");
	a_pair_misalign: assert property (accept && kind == LLU_KIND_PAIRED
		&& !ctrl_q[LLU_CTRL_XNP_BIT] && eff_addr[2:0] != 3'h0
		|=> exc_valid_o && exc_code_o == LLU_EXC_ADDR_ERR)
		else $error("misaligned paired load did not fault");
	a_user_reserved: assert property (accept && kind == LLU_KIND_USER
		&& !ctrl_q[LLU_CTRL_EVA_BIT] |=> exc_valid_o && exc_code_o == LLU_EXC_RESERVED)
		else $error("user-map load without enable not reserved");
	a_pair_reserved: assert property (accept && kind == LLU_KIND_PAIRED
		&& ctrl_q[LLU_CTRL_XNP_BIT] |=> exc_valid_o && exc_code_o == LLU_EXC_RESERVED)
		else $error("paired load with no-pair bit not reserved");
	a_single_addr: assert property (accept && kind == LLU_KIND_SINGLE
		&& eff_addr[1:0] == 2'h0 |=> mem_req_o && mem_vaddr_o == $past(eff_addr, 1))
		else $error("single load address wrong");
	a_pair_second: assert property (state_q == LLU_S_READ_LO && mem_ack_i
		&& kind_q == LLU_KIND_PAIRED && mem_fault_i == LLU_MEM_OK
		|=> mem_req_o && mem_pair_lock_o && mem_vaddr_o == $past(mem_vaddr_o) + LLU_WORD_STEP)
		else $error("paired second read not locked at next word");
	a_pair_writes: assert property (state_q == LLU_S_READ_HI && mem_ack_i
		&& mem_fault_i == LLU_MEM_OK |=> rf_we_o && rf_waddr_o == rt_q
		##1 rf_we_o && rf_waddr_o == rd_q && done_o && link_flag_o && link_addr_o[2:0] == 3'h1)
		else $error("paired writeback order or link wrong");
	a_done_link: assert property (done_o |-> link_flag_o)
		else $error("completion without link flag");
	a_fault_nowrite: assert property (exc_valid_o |-> !rf_we_o && !done_o)
		else $error("faulted load wrote a register");
	a_req_hold: assert property (mem_req_o && !mem_ack_i
		|=> mem_req_o && $stable(mem_vaddr_o))
		else $error("memory request dropped before ack");

	c_single_done: cover property (done_o && kind_q == LLU_KIND_SINGLE);
	c_user_done:   cover property (done_o && kind_q == LLU_KIND_USER);
	c_pair_done:   cover property (done_o && kind_q == LLU_KIND_PAIRED);
	c_fault:       cover property (exc_valid_o && exc_code_o == LLU_EXC_TLB_REFILL);

endmodule // llu_unit

// *** test/llu_mem_model.sv ***
// Stand-in for translation and the memory load path of the load-linked unit.
// Assumes one held read request at a time, dropped by the unit at the ack edge except after the first paired half.
module llu_mem_model
	import llu_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        req_i,
	input  wire logic [31:0] vaddr_i,
	input  wire logic        user_map_i,
	input  wire logic [3:0]  dly_i,
	input  wire logic [1:0]  fault_i,
	input  wire logic [1:0]  seg_i,
	output logic             ack_o,
	output logic      [1:0]  fault_o,
	output logic      [1:0]  seg_o,
	output logic      [31:0] paddr_o,
	output logic      [31:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0]  wait_q;
	logic [31:0] last_vaddr;
	logic        last_umap;
	int          num_reqs;

	////////////////////////////////////////////////////////////////////////////
	// Every address is served as synchronizable storage
	// Wait the set delay, answer one cycle, then toggle the released lines
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o    <= 1'b0;
			fault_o  <= 2'h0;
			seg_o    <= 2'h0;
			paddr_o  <= 32'h0000_0000;
			rdata_o  <= 32'h0000_0000;
			wait_q   <= 4'h0;
			num_reqs <= 0;
		end else if (req_i && !ack_o && wait_q >= dly_i) begin
			ack_o      <= 1'b1;
			fault_o    <= fault_i;
			seg_o      <= seg_i;
			paddr_o    <= vaddr_i + 32'h1000_0000;
			rdata_o    <= {vaddr_i[15:0], vaddr_i[31:16]} ^ 32'h5A5A_5A5A;
			last_vaddr <= vaddr_i;
			last_umap  <= user_map_i;
			num_reqs   <= num_reqs + 1;
			wait_q     <= 4'h0;
		end else begin
			ack_o   <= 1'b0;
			fault_o <= ~fault_o;
			seg_o   <= ~seg_o;
			paddr_o <= ~paddr_o;
			rdata_o <= ~rdata_o;
			wait_q  <= (req_i && !ack_o) ? wait_q + 4'h1 : 4'h0;
		end
	end
endmodule // llu_mem_model

// *** test/tb.sv ***
// Self-checking bench for the load-linked unit: bus, decode, reads, link state.
// Assumes llu_pkg and llu_mem_model are compiled before it.
module tb
	import llu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic        instr_valid_i, link_clear_i, busy_o, mem_req_o, mem_user_map_o;
	logic        mem_pair_lock_o, mem_ack_i, rf_we_o, done_o, exc_valid_o, link_flag_o;
	logic [3:0]  wb_adr_i, wb_sel_i, dly;
	logic [1:0]  mem_fault_i, mem_seg_mode_i, flt, seg;
	logic [4:0]  rf_waddr_o;
	logic [31:0] wb_dat_i, wb_dat_o, instr_i, base_value_i, mem_vaddr_o, mem_paddr_i;
	logic [31:0] mem_rdata_i, rf_wdata_o, link_addr_o, rd;
	logic [31:0] general_register [32];
	llu_exc_t    exc_code_o, exc_seen;
	llu_exc_t    exp_exc [4];
	int          num_errors, comparisons, lock_acks, reqs;

	llu_unit DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .instr_valid_i, .instr_i, .base_value_i,
		.link_clear_i, .busy_o, .mem_req_o, .mem_vaddr_o, .mem_user_map_o,
		.mem_pair_lock_o, .mem_ack_i, .mem_fault_i, .mem_seg_mode_i, .mem_paddr_i,
		.mem_rdata_i, .rf_we_o, .rf_waddr_o, .rf_wdata_o, .done_o, .exc_valid_o,
		.exc_code_o, .link_flag_o, .link_addr_o);

	llu_mem_model mem (.clk_i, .rst_i, .req_i(mem_req_o), .vaddr_i(mem_vaddr_o),
		.user_map_i(mem_user_map_o), .dly_i(dly), .fault_i(flt), .seg_i(seg),
		.ack_o(mem_ack_i), .fault_o(mem_fault_i), .seg_o(mem_seg_mode_i),
		.paddr_o(mem_paddr_i), .rdata_o(mem_rdata_i));

	////////////////////////////////////////////////////////////////////////////
	// Clock at 100 ns period
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// Register file image and count of reads made under the pair lock
	always @(posedge clk_i) begin
		if (rf_we_o === 1'b1)
			general_register[rf_waddr_o] <= rf_wdata_o;
		if (mem_ack_i === 1'b1 && mem_pair_lock_o === 1'b1)
			lock_acks++;
	end

	////////////////////////////////////////////////////////////////////////////
	// Expected memory word, the same pattern the memory stand-in returns
	function automatic logic [31:0] mdata(input logic [31:0] a);
		return {a[15:0], a[31:16]} ^ 32'h5A5A_5A5A;
	endfunction

	// Instruction word: group C, rt, base field, subfield, code, low nine bits
	function automatic logic [31:0] enc(input logic [3:0] sub, input logic [2:0] code,
		input logic [4:0] rt, input logic [8:0] low);
		return {6'h18, rt, 5'h03, sub, code, low};
	endfunction

	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_exc(input string what, input llu_exc_t exp, input llu_exc_t got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %s seen %s", what, exp.name(), got.name());
		end
	endtask

	// One classic Wishbone cycle, held until ack, then a idle cycle
	task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		wb_sel_i <= 4'hF;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20)
			num_errors++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// Offer one instruction and wait for retirement or a fault
	task automatic issue(input logic [31:0] ins, input logic [31:0] base);
		int n;
		n = 0;
		lock_acks = 0;
		instr_i       <= ins;
		base_value_i  <= base;
		instr_valid_i <= 1'b1;
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		while (done_o !== 1'b1 && exc_valid_o !== 1'b1 && n < 40) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 40)
			num_errors++;
		exc_seen = (exc_valid_o === 1'b1) ? exc_code_o : LLU_EXC_NONE;
		@(posedge clk_i);
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge clk_i);
		num_errors++;
		give_verdict();
	end

	// Test sequence
	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, instr_valid_i, link_clear_i} = 6'h20;
		{wb_adr_i, wb_sel_i, dly, flt, seg} = '0;
		{wb_dat_i, instr_i, base_value_i} = '0;
		{num_errors, comparisons, lock_acks} = '0;
		exp_exc = '{LLU_EXC_NONE, LLU_EXC_TLB_REFILL, LLU_EXC_TLB_INVALID, LLU_EXC_WATCH};
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int a = 0; a < 16; a += 4) begin
			wb_cycle(1'b0, a[3:0], 32'h0);
			check_word("reset reg", 32'h0, rd);
		end
		issue(enc(4'h6, 3'h6, 5'd4, 9'h000), 32'h300);
		check_exc("user map off", LLU_EXC_RESERVED, exc_seen);
		wb_cycle(1'b1, LLU_ADDR_CTRL, 32'h2);
		issue(enc(4'h1, 3'h0, 5'd7, 9'h090), 32'h208);
		check_exc("pair off", LLU_EXC_RESERVED, exc_seen);
		wb_cycle(1'b1, LLU_ADDR_CTRL, 32'h0);
		$display("test %s finished", "reserved");
		for (int i = 0; i < 2; i++) begin
			dly <= i ? 4'h3 : 4'h0;
			issue(enc(4'h3, 3'h0, 5'd5, i ? 9'h0FC : 9'h1FC), 32'h104);
			check_exc("single", LLU_EXC_NONE, exc_seen);
			check_word("vaddr", i ? 32'h200 : 32'h100, mem.last_vaddr);
			check_word("rt", mdata(i ? 32'h200 : 32'h100), general_register[5]);
			check_word("link", i ? 32'h1000_0201 : 32'h1000_0101, link_addr_o);
		end
		wb_cycle(1'b0, LLU_ADDR_STATUS, 32'h0);
		check_word("status", 32'h1, rd);
		for (int i = 1; i < 4; i++) begin
			reqs = mem.num_reqs;
			issue(enc(4'h3, 3'h0, 5'd6, i[8:0]), 32'h104);
			check_exc("misalign", LLU_EXC_ADDR_ERR, exc_seen);
			check_word("no read", reqs, mem.num_reqs);
			flt <= i[1:0];
			issue(enc(4'h3, 3'h0, 5'd6, 9'h000), 32'h104);
			check_exc("fault", exp_exc[i], exc_seen);
			flt <= 2'h0;
		end
		$display("test %s finished", "single");
		wb_cycle(1'b1, LLU_ADDR_CTRL, 32'h1);
		issue(enc(4'h6, 3'h6, 5'd8, 9'h000), 32'h300);
		check_exc("cop off", LLU_EXC_CP_UNUSABLE, exc_seen);
		wb_cycle(1'b1, LLU_ADDR_CTRL, 32'h5);
		for (int s = 0; s < 4; s++) begin
			seg <= s[1:0];
			issue(enc(4'h6, 3'h6, 5'd8, 9'h010), 32'h300);
			check_exc("seg", (s == 3) ? LLU_EXC_ADDR_ERR : LLU_EXC_NONE, exc_seen);
			check_word("umap", 32'h1, {31'h0, mem.last_umap});
		end
		check_word("rt umap", mdata(32'h310), general_register[8]);
		seg <= 2'h0;
		wb_cycle(1'b1, LLU_ADDR_CTRL, 32'h0);
		$display("test %s finished", "user map");
		dly <= 4'h1;
		issue(enc(4'h1, 3'h0, 5'd7, {5'd9, 4'h0}), 32'h208);
		check_exc("pair", LLU_EXC_NONE, exc_seen);
		check_word("pair lo", mdata(32'h208), general_register[7]);
		check_word("pair hi", mdata(32'h20C), general_register[9]);
		check_word("locked", 32'h2, lock_acks);
		check_word("pair link", 32'h1000_0209, link_addr_o);
		issue(enc(4'h1, 3'h0, 5'd7, {5'd9, 4'h0}), 32'h204);
		check_exc("pair align", LLU_EXC_ADDR_ERR, exc_seen);
		repeat (20) @(posedge clk_i);
		check_word("kept", 32'h1, {31'h0, link_flag_o});
		wb_cycle(1'b1, LLU_ADDR_STATUS, 32'h0);
		wb_cycle(1'b0, LLU_ADDR_STATUS, 32'h0);
		check_word("cleared", 32'h0, rd);
		issue(enc(4'h3, 3'h0, 5'd5, 9'h000), 32'h400);
		check_word("relink", 32'h1000_0401, link_addr_o);
		link_clear_i <= 1'b1;
		@(posedge clk_i);
		link_clear_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check_word("ext clear", 32'h0, {31'h0, link_flag_o});
		$display("test %s finished", "paired and link");
		give_verdict();
	end
endmodule // tb
